// file: train_pkg.sv
// Package for the serial training pattern generator.
// Assumes a single core clock domain and active-low async reset.
package train_pkg;

	// Fixed part of one training group, in bits
	localparam int unsigned FIXED_BITS   = 192;
	// Least random part and least group length
	localparam int unsigned RAND_MIN     = 192;
	localparam int unsigned GROUP_MIN    = 384;
	// Default framing gap between groups
	localparam int unsigned GAP_DEFAULT  = 0;
	// Fixed segments, first byte sent first, each byte MSB first
	localparam logic [191:0] FIXED_PATTERN = {
		48'h00ff00ff00ff,   // Low-frequency square wave
		24'h008000,         // Positive impulse
		48'h555555555555,   // Half-rate alternating
		24'hffefff,         // Negative impulse
		48'h00ff00ff00ff    // Low-frequency square wave
	};
	// Default LFSR: x^31 + x^28 + 1, maximal length
	localparam int unsigned LFSR_W       = 31;
	localparam logic [30:0] LFSR_TAPS    = 31'h48000000;
	localparam logic [30:0] LFSR_SEED    = 31'h7fffffff;

	typedef enum logic [1:0] {
		ST_DATA  = 2'b00,
		ST_FIXED = 2'b01,
		ST_RAND  = 2'b10,
		ST_GAP   = 2'b11
	} phase_t;

	// Serial lane output bundle
	typedef struct packed {
		logic bit_out;
		logic training;
		logic group_start;
	} lane_t;

endpackage

// file: train_lfsr.sv
// Galois-free Fibonacci LFSR stepping one bit per enable.
// Assumes the tap mask describes a maximal-length polynomial.
module train_lfsr
	import train_pkg::*;
#(
	parameter int unsigned        W    = LFSR_W,
	parameter logic [W-1:0]       TAPS = LFSR_TAPS,
	parameter logic [W-1:0]       SEED = LFSR_SEED
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_step,
	output logic      o_bit
);

	typedef struct packed {
		logic [W-1:0] sr;
	} lfsr_state_t;

	lfsr_state_t state;
	lfsr_state_t next_state;

	// Too short a register or a zero seed would lock the sequence
	if (W < 3 || SEED == '0) begin : bad_lfsr_cfg
		$error("train_lfsr: width below 3 or zero seed");
	end

	// Feedback is the parity of tapped bits; all-zero is never reached
	always_comb begin
		next_state = state;
		if (i_step)
			next_state.sr = {state.sr[W-2:0], ^(state.sr & TAPS)};
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			state.sr <= SEED;
		else
			state <= next_state;
	end

	assign o_bit = state.sr[W-1];

	// Register may never lock up at zero
	lfsr_nonzero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.sr != '0) else $error("lfsr reached all zero");

endmodule

// file: train_gen.sv
// Serial training pattern generator for one transmit lane.
// Assumes i_core_clk is the symbol clock: one lane bit per cycle.
// Normal data arrives serially on i_data_bit and is passed through.

module train_gen
	import train_pkg::*;
#(
	parameter int unsigned RAND_BITS = RAND_MIN,
	parameter int unsigned GAP_BITS  = GAP_DEFAULT
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_train_req,
	input  wire logic i_data_bit,
	input  wire logic i_gap_bit,
	output lane_t     o_lane
);

	// Counter wide enough for long random or gap runs
	localparam int unsigned CNT_W = 16;

	// Whole sequencer state in one record
	typedef struct packed {
		phase_t           phase;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] grp_len;
		lane_t            lane;
	} gen_state_t;

	gen_state_t state;
	gen_state_t next_state;
	logic       rand_bit;
	logic       rand_step;

	// Random part shorter than 192 bits would break the group length
	if (RAND_BITS < RAND_MIN || FIXED_BITS + RAND_BITS < GROUP_MIN) begin : bad_rand_len
		$error("train_gen: random segment shorter than allowed");
	end
	// The shared counter must hold every segment and gap length
	if (RAND_BITS >= (1 << CNT_W) || GAP_BITS >= (1 << CNT_W)) begin : bad_cnt_width
		$error("train_gen: count too wide for counter");
	end

	train_lfsr u_lfsr (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_step     (rand_step),
		.o_bit      (rand_bit)
	);

	// Bit picked from fixed pattern, index 0 is the first bit sent
	function automatic logic fixed_bit(input logic [CNT_W-1:0] idx);
		fixed_bit = FIXED_PATTERN[FIXED_BITS - 1 - idx];
	endfunction

	// Last count of a segment; shared by the sequencer and its checks
	function automatic logic seg_last(input phase_t ph, input logic [CNT_W-1:0] c);
		logic last;
		last = 1'b0;
		case (ph)
			ST_FIXED: last = (c == CNT_W'(FIXED_BITS - 1));
			ST_RAND:  last = (c == CNT_W'(RAND_BITS - 1));
			ST_GAP:   last = (c == CNT_W'(GAP_BITS - 1));
			default:  last = 1'b0;
		endcase
		seg_last = last;
	endfunction

	// LFSR steps exactly when one of its bits is loaded into the lane flop;
	// stepping a cycle late would send the first random bit twice
	assign rand_step = (state.phase == ST_FIXED && seg_last(state.phase, state.cnt))
		|| (state.phase == ST_RAND && !seg_last(state.phase, state.cnt));

	// One bit per cycle; group boundary is the end of the random part
	always_comb begin
		next_state                  = state;
		next_state.lane.group_start = 1'b0;
		case (state.phase)
			ST_DATA: begin
				next_state.lane.bit_out  = i_data_bit;
				next_state.lane.training = 1'b0;
				if (i_train_req) begin
					next_state.phase            = ST_FIXED;
					next_state.cnt              = '0;
					next_state.lane.group_start = 1'b1;
					next_state.lane.training    = 1'b1;
					next_state.lane.bit_out     = fixed_bit('0);
				end
			end
			ST_FIXED: begin
				// Segments 1..5 in sequence
				if (seg_last(state.phase, state.cnt)) begin
					next_state.phase        = ST_RAND;
					next_state.cnt          = '0;
					next_state.lane.bit_out = rand_bit;
				end else begin
					next_state.cnt          = state.cnt + 1'b1;
					next_state.lane.bit_out = fixed_bit(state.cnt + 1'b1);
				end
			end
			ST_RAND: begin
				if (seg_last(state.phase, state.cnt)) begin
					next_state.cnt = '0;
					if (GAP_BITS != 0) begin
						next_state.phase        = ST_GAP;
						next_state.lane.bit_out = i_gap_bit;
					end else if (i_train_req) begin
						next_state.phase            = ST_FIXED;
						next_state.lane.group_start = 1'b1;
						next_state.lane.bit_out     = fixed_bit('0);
					end else begin
						next_state.phase         = ST_DATA;
						next_state.lane.training = 1'b0;
						next_state.lane.bit_out  = i_data_bit;
					end
				end else begin
					next_state.cnt          = state.cnt + 1'b1;
					next_state.lane.bit_out = rand_bit;
				end
			end
			ST_GAP: begin
				// Framing bits follow the group, then repeat or leave
				if (seg_last(state.phase, state.cnt)) begin
					next_state.cnt = '0;
					if (i_train_req) begin
						next_state.phase            = ST_FIXED;
						next_state.lane.group_start = 1'b1;
						next_state.lane.bit_out     = fixed_bit('0);
					end else begin
						next_state.phase         = ST_DATA;
						next_state.lane.training = 1'b0;
						next_state.lane.bit_out  = i_data_bit;
					end
				end else begin
					next_state.cnt          = state.cnt + 1'b1;
					next_state.lane.bit_out = i_gap_bit;
				end
			end
			default: begin
				next_state.phase = ST_DATA;
				next_state.cnt   = '0;
			end
		endcase
		// Cycles since the last group start, held at its top value
		if (next_state.lane.group_start)
			next_state.grp_len = '0;
		else if (state.grp_len != '1)
			next_state.grp_len = state.grp_len + 1'b1;
	end

	// Async reset returns the lane to idle data pass-through
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state.phase   <= ST_DATA;
			state.cnt     <= '0;
			state.grp_len <= '0;
			state.lane    <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Lane bits come straight from the state flops
	assign o_lane = state.lane;

	// Fixed-part checks, by position within the group
	first_square_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.lane.group_start |-> !state.lane.bit_out ##1 !state.lane.bit_out [*7]
		##1 state.lane.bit_out [*8]) else $error("square wave wrong");
	pos_impulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.lane.group_start |-> ##48 !state.lane.bit_out [*8]
		##1 state.lane.bit_out ##1 !state.lane.bit_out [*7]) else $error("impulse wrong");
	nyquist_bits_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.lane.group_start |-> ##72 !state.lane.bit_out ##1 state.lane.bit_out
		##1 !state.lane.bit_out ##1 state.lane.bit_out) else $error("alternating wrong");
	neg_impulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.lane.group_start |-> ##120 state.lane.bit_out [*8]
		##1 state.lane.bit_out [*3] ##1 !state.lane.bit_out) else $error("neg impulse wrong");
	last_square_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.lane.group_start |-> ##144 !state.lane.bit_out [*8]
		##1 state.lane.bit_out [*8]) else $error("fifth segment wrong");

	// Segment order and group length
	random_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		state.lane.group_start |-> ##192 (state.phase == ST_RAND)) else $error("random late");
	// No new group before the previous one has run its full length
	group_length_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state.lane.training && state.grp_len < CNT_W'(GROUP_MIN - 1))
		|=> !state.lane.group_start) else $error("group cut short");

	// Entry, repeat and exit only at group boundaries
	request_start_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state.phase == ST_DATA && i_train_req) |=> state.lane.group_start)
		else $error("no start");
	repeat_group_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state.phase == ST_RAND && seg_last(state.phase, state.cnt) && GAP_BITS == 0
		&& i_train_req) |=> state.lane.group_start) else $error("no repeat");
	group_exit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state.phase == ST_RAND && seg_last(state.phase, state.cnt) && GAP_BITS == 0
		&& !i_train_req) |=> (state.phase == ST_DATA && !state.lane.training))
		else $error("no return to data");
	exit_boundary_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(state.lane.training) |-> ($past(state.phase) != ST_FIXED
		&& seg_last($past(state.phase), $past(state.cnt)))) else $error("left mid group");

	// Normal data passes through with one cycle of latency while idle
	data_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state.phase == ST_DATA && !i_train_req) |=> (!state.lane.training
		&& state.lane.bit_out == $past(i_data_bit))) else $error("data not passed");

endmodule

// file: lane_rx_model.sv
// Far-end lane receiver model: gathers the lane bits of each group.
// Assumes one lane bit per core clock, group_start on bit zero.
module lane_rx_model
	import train_pkg::*;
(
	input  wire logic    i_core_clk,
	input  wire logic    i_rst_n,
	input  wire lane_t   i_lane,
	output logic [383:0] o_bits,
	output logic [9:0]   o_count
);
	timeunit 1ns;
	timeprecision 1ps;

	// Shift in training bits; count restarts at each group start
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bits  <= '0;
			o_count <= '0;
		end else if (i_lane.training) begin
			o_bits  <= {o_bits[382:0], i_lane.bit_out};
			o_count <= i_lane.group_start ? 10'h001 : o_count + 10'h001;
		end
	end
endmodule

// file: tb_train_gen.sv
// Testbench for the training pattern generator.
// Assumes default parameters: 192 random bits and no framing gap.
module tb_train_gen;
	timeunit 1ns;
	timeprecision 1ps;
	import train_pkg::*;

	`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
		$display("mismatch %s exp %0h got %0h", nm, e, g); end end

	logic         i_core_clk  = 1'b0;
	logic         i_rst_n     = 1'b0;
	logic         i_train_req = 1'b0;
	logic         i_data_bit  = 1'b0;
	logic         i_gap_bit   = 1'b0;
	lane_t        o_lane;
	logic [383:0] rx_bits;
	logic [9:0]   rx_count;
	int           bad_count   = 0;
	int           n_checks    = 0;

	// 50 MHz symbol clock
	always #10 i_core_clk = ~i_core_clk;

	train_gen train_gen_i (
		.i_core_clk  (i_core_clk),
		.i_rst_n     (i_rst_n),
		.i_train_req (i_train_req),
		.i_data_bit  (i_data_bit),
		.i_gap_bit   (i_gap_bit),
		.o_lane      (o_lane)
	);

	lane_rx_model lane_rx_model_i (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_lane     (o_lane),
		.o_bits     (rx_bits),
		.o_count    (rx_count)
	);

	task automatic step;
		@(posedge i_core_clk);
		#1;
	endtask

	task automatic print_verdict;
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Normal data passes with one cycle of latency
	task automatic t_pass;
		logic [7:0] pat;
		pat = 8'h4d;
		for (int i = 0; i < 8; i++) begin
			@(posedge i_core_clk) i_data_bit <= pat[i];
			#1;
			if (i > 0) `CHK("bit_out", pat[i-1], o_lane.bit_out)
			`CHK("training", 1'b0, o_lane.training)
		end
		@(posedge i_core_clk) i_data_bit <= 1'b1;
		#1;
		`CHK("bit_out", pat[7], o_lane.bit_out)
	endtask

	// One whole group; request dropped after its first bit or held
	task automatic t_group(input logic drop);
		int k;
		k = 0;
		while (o_lane.group_start !== 1'b1 && k < 4) begin
			step;
			k++;
		end
		`CHK("group_start", 1'b1, o_lane.group_start)
		@(posedge i_core_clk) if (drop) i_train_req <= 1'b0;
		#1;
		k = 0;
		// A dropped request must not cut the group short
		while (rx_count !== 10'h180 && k < 400) begin
			`CHK("training", 1'b1, o_lane.training)
			step;
			k++;
		end
		`CHK("group_len", 10'h180, rx_count)
		`CHK("fixed", FIXED_PATTERN, rx_bits[383:192])
		`CHK("prbs_live", 1'b1, |rx_bits[191:0])
		// Recurrence of x^31 + x^28 + 1, whatever the seed or phase
		for (int n = 0; n < 161; n++)
			`CHK("prbs", rx_bits[191-n] ^ rx_bits[188-n], rx_bits[160-n])
		if (drop) begin
			`CHK("training", 1'b0, o_lane.training)
			`CHK("bit_out", i_data_bit, o_lane.bit_out)
		end else
			`CHK("group_start", 1'b1, o_lane.group_start)
	endtask

	// Reset in mid-group clears the lane at once
	task automatic t_reset;
		@(posedge i_core_clk) i_train_req <= 1'b1;
		repeat (20) step;
		@(posedge i_core_clk) i_rst_n <= 1'b0;
		#1;
		`CHK("lane_reset", 3'h0, o_lane)
		@(posedge i_core_clk) i_rst_n <= 1'b1;
		i_train_req <= 1'b0;
		#1;
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		t_pass;
		@(posedge i_core_clk) i_train_req <= 1'b1;
		#1;
		t_group(1'b1);
		@(posedge i_core_clk) i_train_req <= 1'b1;
		#1;
		t_group(1'b0);
		t_group(1'b1);
		t_reset;
		t_pass;
		print_verdict;
	end

	// Watchdog: the tests need about 1,200 cycles
	initial begin
		#200000;
		bad_count++;
		print_verdict;
	end
endmodule
